/* dv/ilm_checker.sv */
/*
 ilm_checker: timing relations at the ilm_core ports.
 assumes: bound onto ilm_core, one clock, async active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module ilm_checker #(
    parameter int NUM_SRC = 8
) (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // apb phase and error
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pslverr,
    // processor side
    input wire logic       low_power,
    input wire logic       cpu_ack,
    input wire logic [2:0] irq_level,
    input wire logic [7:0] ack_id,
    input wire logic       ack_valid,
    input wire logic       spurious,
    input wire logic       wakeup
);
    // single domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ack_answer_a: assert property (cpu_ack |=> ack_valid)
        else $error("acknowledge not answered next cycle");
    ack_cause_a: assert property (ack_valid |-> $past(cpu_ack))
        else $error("answer without acknowledge");
    spur_id_a: assert property (spurious |-> ack_valid && ack_id == 8'hFF)
        else $error("spurious answer without spurious id");
    id_hold_a: assert property (!ack_valid |-> $stable(ack_id))
        else $error("ack id moved between answers");
    id_range_a: assert property (ack_valid && !spurious |-> ack_id < NUM_SRC)
        else $error("ack id names no source");
    wake_mode_a: assert property (wakeup |-> $past(low_power))
        else $error("wakeup outside low-power mode");
    nmi_wake_a: assert property ((low_power && irq_level == 3'h7) [*3] |-> wakeup)
        else $error("level 7 request did not wake");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");
endmodule : ilm_checker
`default_nettype wire

/* dv/ilm_core_bench.sv */
/*
 ilm_core_bench: directed checks of masking, acknowledge and wakeup.
 assumes: ilm_pkg, ilm_core, ilm_cpu_model and ilm_checker compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module ilm_core_bench;
    localparam int NUM_SRC = 4;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, cpu_ack, ack_valid, spurious, wakeup, last_err;
    logic [3:0] src_req = 4'h0, module_mask = 4'h0, ack_dly = 4'h0;
    logic low_power = 1'b0, ack_go = 1'b0;
    logic [2:0] irq_level;
    logic [7:0] ack_id;
    int mismatches = 0, tests_run = 0;

    ilm_core #(.NUM_SRC(NUM_SRC)) dut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_req(src_req), .module_mask(module_mask), .low_power(low_power),
        .cpu_ack(cpu_ack), .irq_level(irq_level), .ack_id(ack_id), .ack_valid(ack_valid),
        .spurious(spurious), .wakeup(wakeup));
    ilm_cpu_model core (.clk(clk), .rst_n(rst_n), .ack_go(ack_go), .ack_dly(ack_dly),
        .cpu_ack(cpu_ack));

    // 250 MHz
    always #2 clk = ~clk;

    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        mismatches += (g !== e);
        if (g !== e) $display("[ERR] %s expected %h seen %h", n, e, g);
    endtask : chk
    task automatic give_up(input string n);
        chk(n, 32'h1, 32'h0);
        stop_test();
    endtask : give_up
    // request held until pready is seen; prdata taken at that same edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        repeat (20) if (pready !== 1'b1) @(posedge clk);
        if (pready !== 1'b1) give_up("pready");
        last_err = pslverr;
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask : rdc
    function automatic logic [2:0] cur(input logic w);
        return w ? {2'h0, wakeup} : irq_level;
    endfunction : cur
    // w selects wakeup, else irq_level
    task automatic wt(input logic w, input logic [2:0] e);
        repeat (20) if (cur(w) !== e) @(posedge clk);
        if (cur(w) !== e) give_up(w ? "wakeup" : "irq_level");
        chk(w ? "wakeup" : "irq_level", {29'h0, e}, {29'h0, cur(w)});
    endtask : wt
    task automatic ack(input logic [3:0] dly, input logic [7:0] id, input logic sp);
        ack_dly <= dly;
        ack_go  <= 1'b1;
        @(posedge clk);
        ack_go  <= 1'b0;
        repeat (30) if (ack_valid !== 1'b1) @(posedge clk);
        if (ack_valid !== 1'b1) give_up("ack_valid");
        chk("ack_id", {24'h0, id}, {24'h0, ack_id});
        chk("spurious", {31'h0, sp}, {31'h0, spurious});
        @(posedge clk);
    endtask : ack
    // level 7 source is still gated by the source masks; only the cpu mask does not block it
    task automatic pulse7;
        src_req[3] <= 1'b1;
        repeat (3) @(posedge clk);
        src_req[3] <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : pulse7

    task automatic t_reset;
        rdc("cpu_level_mask", ilm_pkg::ADDR_CPU_LVL, 32'h7);
        rdc("controller_source_mask", ilm_pkg::ADDR_SRC_MASK, 32'((1 << NUM_SRC) - 1));
        for (int i = 0; i < NUM_SRC; i++)
            rdc("source_level_control", ilm_pkg::ADDR_LVL_BASE + 8'(4 * i), 32'h0);
        rdc("low_power_wake_control", ilm_pkg::ADDR_WAKE, 32'h0);
        rdc("unmapped", 8'h14, 32'h0);
        chk("pslverr", 32'h1, {31'h0, last_err});
        $display("test reset done");
    endtask : t_reset
    task automatic t_level;
        for (int i = 0; i < NUM_SRC; i++)
            apb(1'b1, ilm_pkg::ADDR_LVL_BASE + 8'(4 * i), (i == 0) ? 32'h3 : 32'(4 + i));
        apb(1'b1, ilm_pkg::ADDR_SRC_MASK, 32'h0);
        apb(1'b1, ilm_pkg::ADDR_CPU_LVL, 32'h2);
        src_req <= 4'h3;
        wt(1'b0, 3'h5);
        ack(4'h0, 8'h01, 1'b0);
        module_mask <= 4'h2;
        wt(1'b0, 3'h3);
        apb(1'b1, ilm_pkg::ADDR_CPU_LVL, 32'h3);
        wt(1'b0, 3'h0);
        apb(1'b1, ilm_pkg::ADDR_CPU_LVL, 32'h2);
        wt(1'b0, 3'h3);
        module_mask <= 4'h0;
        src_req <= 4'h0;
        wt(1'b0, 3'h0);
        $display("test level done");
    endtask : t_level
    task automatic t_nmi;
        apb(1'b1, ilm_pkg::ADDR_CPU_LVL, 32'h7);
        pulse7();
        chk("irq_level", 32'h7, {29'h0, irq_level});
        ack(4'h5, 8'h03, 1'b0);
        wt(1'b0, 3'h0);
        $display("test nmi done");
    endtask : t_nmi
    task automatic t_spur;
        apb(1'b1, ilm_pkg::ADDR_CPU_LVL, 32'h0);
        src_req <= 4'h1;
        wt(1'b0, 3'h3);
        apb(1'b1, ilm_pkg::ADDR_SRC_MASK, 32'h1);
        ack(4'h0, 8'hFF, 1'b1);
        apb(1'b1, ilm_pkg::ADDR_SRC_MASK, 32'h0);
        wt(1'b0, 3'h3);
        apb(1'b1, ilm_pkg::ADDR_CPU_LVL, 32'h3);
        wt(1'b0, 3'h0);
        apb(1'b1, ilm_pkg::ADDR_SRC_MASK, 32'h1);
        apb(1'b1, ilm_pkg::ADDR_CPU_LVL, 32'h0);
        repeat (3) @(posedge clk);
        wt(1'b0, 3'h0);
        src_req <= 4'h0;
        apb(1'b1, ilm_pkg::ADDR_SRC_MASK, 32'h0);
        $display("test spurious done");
    endtask : t_spur
    task automatic t_wake;
        apb(1'b1, ilm_pkg::ADDR_WAKE, 32'h50);
        low_power <= 1'b1;
        src_req <= 4'h4;
        wt(1'b1, 3'h1);
        apb(1'b1, ilm_pkg::ADDR_WAKE, 32'h70);
        wt(1'b1, 3'h0);
        pulse7();
        wt(1'b1, 3'h1);
        ack(4'h0, 8'h03, 1'b0);
        wt(1'b1, 3'h0);
        low_power <= 1'b0;
        src_req <= 4'h0;
        $display("test wake done");
    endtask : t_wake
    // reset again mid-run: the source 0 level written earlier must fall back to disabled, the cpu mask to 7
    task automatic t_rerun;
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdc("source_level_control", ilm_pkg::ADDR_LVL_BASE, 32'h0);
        rdc("cpu_level_mask", ilm_pkg::ADDR_CPU_LVL, 32'h7);
        chk("irq_level", 32'h0, {29'h0, irq_level});
        $display("test rerun done");
    endtask : t_rerun

    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_level();
        t_nmi();
        t_spur();
        t_wake();
        t_rerun();
        stop_test();
    end
endmodule : ilm_core_bench

bind ilm_core ilm_checker #(.NUM_SRC(NUM_SRC)) u_chk (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pslverr(pslverr),
    .low_power(low_power), .cpu_ack(cpu_ack), .irq_level(irq_level), .ack_id(ack_id),
    .ack_valid(ack_valid), .spurious(spurious), .wakeup(wakeup));
`default_nettype wire

/* dv/ilm_cpu_model.sv */
/*
 ilm_cpu_model: core side, one acknowledge per bench command.
 assumes: same clock as the block; ack_go is a one-cycle pulse.
*/
`timescale 1ns/1ns
`default_nettype none
module ilm_cpu_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // command: acknowledge after ack_dly+1 idle cycles
    input  wire logic       ack_go,
    input  wire logic [3:0] ack_dly,
    // to the block
    output logic            cpu_ack
);
    logic [4:0] cnt_r;
    // acks whatever is pending by then, as a busy core would
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_r <= 5'h00;
        else
            cnt_r <= ack_go ? {1'b0, ack_dly} + 5'h01 : cnt_r - {4'h0, cnt_r != 5'h00};
    end
    // one-cycle pulse: a held ack would count twice
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cpu_ack <= 1'b0;
        else
            cpu_ack <= (cnt_r == 5'h01);
    end
endmodule : ilm_cpu_model
`default_nettype wire

/* verilog/ilm_core.sv */
/*
 ilm_core: interrupt level masking, acknowledge and wakeup masking.
 assumes: APB slave on clk; source requests from pins (synchronised here);
 low_power and cpu_ack come from core logic on the same clock; cpu level mask is an APB register.
*/
`timescale 1ns/1ns
`default_nettype none
module ilm_core #(
    parameter int NUM_SRC = ilm_pkg::NUM_SRC_DEF
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // request sources (async) and module masks
    input  wire logic [NUM_SRC-1:0] src_req,
    input  wire logic [NUM_SRC-1:0] module_mask,
    // processor side
    input  wire logic               low_power,
    input  wire logic               cpu_ack,
    output logic [2:0]              irq_level,
    output logic [7:0]              ack_id,
    output logic                    ack_valid,
    output logic                    spurious,
    output logic                    wakeup
);
    // elaboration check: NUM_SRC kept to 1..24, well inside what ack ids and the level window hold
    generate
        if (NUM_SRC < 1 || NUM_SRC > 24)
        begin : g_bad_num_src
            $error("ilm_core: NUM_SRC must be 1..24");
        end
    endgenerate

    // register state
    logic [NUM_SRC-1:0]   controller_source_mask_r;
    logic [2:0]           cpu_level_mask_r;
    logic [2:0]           low_power_wake_control_r;
    logic [NUM_SRC*3-1:0] source_level_control_r;
    logic [NUM_SRC-1:0]   sync1_r;
    logic [NUM_SRC-1:0]   sync2_r;
    logic [NUM_SRC-1:0]   prev_r;
    logic [NUM_SRC-1:0]   nmi_pend_r;
    logic [2:0]           irq_level_r;
    logic [7:0]           ack_id_r;
    logic                 ack_valid_r;
    logic                 spurious_r;
    logic                 wakeup_r;
    logic [31:0]          prdata_r;

    // bus decode
    wire                  wr_en      = psel && penable && pwrite;
    // read data is loaded at the setup edge so it stands at the access edge
    wire                  rd_setup   = psel && !penable && !pwrite;
    wire                  hit_mask   = (paddr == ilm_pkg::ADDR_SRC_MASK);
    wire                  hit_cpu    = (paddr == ilm_pkg::ADDR_CPU_LVL);
    wire                  hit_wake   = (paddr == ilm_pkg::ADDR_WAKE);
    wire                  hit_stat   = (paddr == ilm_pkg::ADDR_STATUS);
    wire                  hit_pend   = (paddr == ilm_pkg::ADDR_PEND);
    wire [7:0]            lvl_off    = paddr - ilm_pkg::ADDR_LVL_BASE;
    wire                  hit_lvl    = (paddr >= ilm_pkg::ADDR_LVL_BASE)
                                       && (lvl_off[1:0] == 2'h0)
                                       && (lvl_off[7:2] < 6'(NUM_SRC));
    wire                  hit_any    = hit_mask | hit_cpu | hit_wake | hit_stat
                                       | hit_pend | hit_lvl;
    wire [5:0]            lvl_idx    = lvl_off[7:2];
    // per-register write strobes, all taken at the access edge
    wire                  wr_mask    = wr_en && hit_mask;
    wire                  wr_cpu     = wr_en && hit_cpu;
    wire                  wr_wake    = wr_en && hit_wake;
    wire                  wr_lvl     = wr_en && hit_lvl;

    // per-source qualification
    logic [NUM_SRC-1:0]   is_nmi;
    logic [NUM_SRC-1:0]   pend;
    logic [NUM_SRC-1:0]   qual;
    logic [NUM_SRC-1:0]   nmi_edge;
    logic [NUM_SRC-1:0]   nmi_take;
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++)
        begin : g_src
            wire [2:0] lv = source_level_control_r[g*3 +: 3];
            wire       en = !controller_source_mask_r[g] && !module_mask[g];
            assign is_nmi[g]   = (lv == ilm_pkg::LVL_NMI);
            // level 7 edge-sensitive
            assign nmi_edge[g] = is_nmi[g] && sync2_r[g] && !prev_r[g];
            // level 0 is the disabled reset state
            assign pend[g]     = en && (lv != ilm_pkg::LVL_NONE)
                                 && (is_nmi[g] ? nmi_pend_r[g] : sync2_r[g]);
            // blocked at or below the cpu mask, except level 7
            assign qual[g]     = pend[g] && (is_nmi[g] || (lv > cpu_level_mask_r));
        end
    endgenerate

    // highest qualified level and its source
    logic       win_any;
    logic [2:0] win_lvl;
    logic [7:0] win_id;
    ilm_prio #(
        .NUM_SRC (NUM_SRC)
    ) u_prio (
        .req     (qual),
        .lvl     (source_level_control_r),
        .any     (win_any),
        .win_lvl (win_lvl),
        .win_id  (win_id)
    );

    // the ack consumes a level 7 edge only for the winning source
    generate
        for (g = 0; g < NUM_SRC; g++)
        begin : g_take
            assign nmi_take[g] = cpu_ack && win_any && (win_id == 8'(g)) && is_nmi[g];
        end
    endgenerate

    // next level 7 latch state; a new edge wins over the ack clear
    wire [NUM_SRC-1:0] nmi_pend_nxt = (nmi_pend_r & ~nmi_take) | nmi_edge;

    // wake level clamp into 0-6
    wire [2:0] wake_lvl = (low_power_wake_control_r > ilm_pkg::LVL_WAKE_MAX)
                          ? ilm_pkg::LVL_WAKE_MAX : low_power_wake_control_r;
    wire       wake_hit = win_any && (win_lvl > wake_lvl);

    // ack id: winner, or the spurious id when nothing qualifies
    wire [7:0] ack_id_nxt = !cpu_ack ? ack_id_r
                            : (win_any ? win_id : ilm_pkg::SPURIOUS_ID);

    // read mux
    logic [31:0] rd_val;
    always_comb
    begin
        // unmapped addresses and unused bits read as zero
        rd_val = 32'h00000000;
        if (hit_mask)
            rd_val[NUM_SRC-1:0] = controller_source_mask_r;
        else if (hit_cpu)
            rd_val[2:0] = cpu_level_mask_r;
        else if (hit_wake)
            rd_val[ilm_pkg::WAKE_MSB:ilm_pkg::WAKE_LSB] = low_power_wake_control_r;
        else if (hit_stat)
            rd_val[11:0] = {win_any, win_id, win_lvl};
        else if (hit_pend)
            rd_val[NUM_SRC-1:0] = pend;
        else if (hit_lvl)
            rd_val[2:0] = source_level_control_r[lvl_idx*3 +: 3];
    end

    // apb answers in the access cycle, unmapped is an error
    // no wait states: read data was already loaded in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit_any;
    assign prdata  = prdata_r;

    // two-flop synchroniser on the request pins
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= src_req;
            sync2_r <= sync1_r;
        end
    end

    // edge history; resets low like an idle pin, so no false edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prev_r <= '0;
        else
            prev_r <= sync2_r;
    end

    // level 7 latch
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            nmi_pend_r <= '0;
        else
            nmi_pend_r <= nmi_pend_nxt;
    end

    // source mask: every source masked out of reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            controller_source_mask_r <= ilm_pkg::SRC_MASK_RST[NUM_SRC-1:0];
        else if (wr_mask)
            controller_source_mask_r <= pwdata[NUM_SRC-1:0];
    end

    // cpu level mask; software raises it before masking a source
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cpu_level_mask_r <= ilm_pkg::CPU_LVL_RST;
        else if (wr_cpu)
            cpu_level_mask_r <= pwdata[2:0];
    end

    // wake level kept raw; the clamp sits in front of the compare
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            low_power_wake_control_r <= ilm_pkg::WAKE_RST;
        else if (wr_wake)
            low_power_wake_control_r <= pwdata[ilm_pkg::WAKE_MSB:ilm_pkg::WAKE_LSB];
    end

    // per-source levels, disabled out of reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            source_level_control_r <= {NUM_SRC{ilm_pkg::SRC_LVL_RST}};
        else if (wr_lvl)
            source_level_control_r[lvl_idx*3 +: 3] <= pwdata[2:0];
    end

    // read data capture
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prdata_r <= 32'h00000000;
        else if (rd_setup)
            prdata_r <= rd_val;
    end

    // presented level, zero when nothing qualifies
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_level_r <= 3'h0;
        else
            irq_level_r <= win_any ? win_lvl : 3'h0;
    end

    // answer pulse one cycle after the ack
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ack_valid_r <= 1'b0;
        else
            ack_valid_r <= cpu_ack;
    end

    // ack with no qualified requester is spurious
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            spurious_r <= 1'b0;
        else
            spurious_r <= cpu_ack && !win_any;
    end

    // source of the last ack, held until the next one
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ack_id_r <= 8'h00;
        else
            ack_id_r <= ack_id_nxt;
    end

    // wake only in low-power mode, against the clamped level
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wakeup_r <= 1'b0;
        else
            wakeup_r <= low_power && wake_hit;
    end

    assign irq_level = irq_level_r;
    assign ack_id    = ack_id_r;
    assign ack_valid = ack_valid_r;
    assign spurious  = spurious_r;
    assign wakeup    = wakeup_r;
endmodule : ilm_core
`default_nettype wire

/* verilog/ilm_pkg.sv */
/*
 ilm_pkg: constants for the interrupt level masking block.
 assumes: used as ilm_pkg::name, nothing imported.
*/
`default_nettype none
package ilm_pkg;
    // source and level geometry
    localparam int          NUM_SRC_DEF   = 8;
    localparam int          LVL_W         = 3;
    localparam logic [2:0]  LVL_NMI       = 3'h7;
    localparam logic [2:0]  LVL_WAKE_MAX  = 3'h6;
    localparam logic [2:0]  LVL_NONE      = 3'h0;
    // register byte addresses
    localparam logic [7:0]  ADDR_SRC_MASK = 8'h00;
    localparam logic [7:0]  ADDR_CPU_LVL  = 8'h04;
    localparam logic [7:0]  ADDR_WAKE     = 8'h08;
    localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
    localparam logic [7:0]  ADDR_PEND     = 8'h10;
    localparam logic [7:0]  ADDR_LVL_BASE = 8'h20;
    // wake control field: bits 6:4
    localparam int          WAKE_LSB      = 4;
    localparam int          WAKE_MSB      = 6;
    // reset values
    localparam logic [31:0] SRC_MASK_RST  = 32'hFFFFFFFF;
    localparam logic [2:0]  CPU_LVL_RST   = 3'h7;
    localparam logic [2:0]  SRC_LVL_RST   = 3'h0;
    localparam logic [2:0]  WAKE_RST      = 3'h0;
    // spurious vector value on ack
    localparam logic [7:0]  SPURIOUS_ID   = 8'hFF;
endpackage : ilm_pkg
`default_nettype wire

/* verilog/ilm_prio.sv */
/*
 ilm_prio: picks highest level among qualified requests, lowest index on ties.
 assumes: inputs same clock, purely combinational.
*/
`timescale 1ns/1ns
`default_nettype none
module ilm_prio #(
    parameter int NUM_SRC = 8
) (
    // per-source qualified request and level
    input  wire logic [NUM_SRC-1:0]   req,
    input  wire logic [NUM_SRC*3-1:0] lvl,
    // winner
    output logic                      any,
    output logic [2:0]                win_lvl,
    output logic [7:0]                win_id
);
    // linear scan; fine for a few dozen sources
    always_comb
    begin
        any     = 1'b0;
        win_lvl = 3'h0;
        win_id  = 8'h00;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (req[i] && (lvl[i*3 +: 3] > win_lvl))
            begin
                any     = 1'b1;
                win_lvl = lvl[i*3 +: 3];
                win_id  = 8'(i);
            end
        end
    end
endmodule : ilm_prio
`default_nettype wire
